// File: rtl/ccs_unit.sv
// Common command interpreter with event status, status byte and setup store.
`timescale 1ns/1ps
// What this block does
// - Clear status clears events, flags; output kept.
// - Event enable command loads mask.
// - Event enable query returns mask unchanged.
// - Event register query returns then clears.
// - Identification query returns identification code.
// - Learn query returns present setup word.
// - Operation complete waits, sets flag and bit.
// - Operation query answers 1 after idle.
// - Recall restores setup from location one-four.
// - Save stores setup into location one-four.
// - Reset restores fixed default state.
// - Service enable command loads mask.
// - Service enable query returns mask.
// - Status byte query returns status byte.
// - Trigger command pulses internal trigger.
// - Self test returns zero on pass.
// - Wait command stalls until nothing pending.
module ccs_unit (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   cmd_valid_in,
    input  wire ccs_pkg::ccs_cmd_type   cmd_code_in,
    input  wire logic [7:0]             cmd_arg_in,
    input  wire logic                   op_pending_in,
    input  wire logic                   selftest_fail_in,
    input  wire logic [15:0]            setup_in,
    input  wire logic                   resp_taken_in,
    output logic                        cmd_ready_out,
    output logic                        resp_valid_out,
    output logic [15:0]                 resp_data_out,
    output logic [15:0]                 setup_out,
    output logic                        setup_load_out,
    output logic                        trigger_out,
    output logic                        srq_out,
    output logic [7:0]                  stb_out,
    output logic                        opc_flag_out
);
    import ccs_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_OPC, ST_WAIT_OPCQ, ST_WAIT_WAI} ccs_state_type;

    ccs_state_type state_q;
    logic [7:0]  ese_q;
    logic [7:0]  sre_q;
    logic [7:0]  esr_q;
    logic        opc_flag_q;
    logic        cmd_ready_q;
    logic        resp_valid_q;
    logic [15:0] resp_data_q;
    logic [15:0] setup_q;
    logic        setup_load_q;
    logic        trigger_q;
    logic        srq_q;
    logic [7:0]  stb_q;

    ccs_setup_if sif ();
    ccs_setup_mem #(.DEPTH(CCS_LOCS)) u_mem (.clk_in(clk_in), .port(sif));

    wire take      = cmd_valid_in && cmd_ready_q;
    wire loc_ok    = (cmd_arg_in >= 8'h01) && (cmd_arg_in <= 8'h04);
    wire is_sav    = take && (cmd_code_in == CCS_CMD_SAV) && loc_ok;
    wire is_rcl    = take && (cmd_code_in == CCS_CMD_RCL) && loc_ok;
    wire bad_loc   = take && ((cmd_code_in == CCS_CMD_SAV) || (cmd_code_in == CCS_CMD_RCL))
                     && !loc_ok;
    wire idle_ops  = !op_pending_in;
    wire opc_done  = (state_q == ST_WAIT_OPC) && idle_ops;
    wire [7:0] esr_sum = esr_q & ese_q;
    wire [7:0] stb_d   = {1'b0, srq_q, |esr_sum, resp_valid_q, 4'h0};
    wire srq_d     = |(stb_d & sre_q & 8'hBF);

    assign sif.wr    = is_sav;
    assign sif.addr  = 2'(cmd_arg_in - 8'h01);
    assign sif.wdata = setup_in;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q      <= ST_IDLE;
            ese_q        <= CCS_ESE_RST;
            sre_q        <= CCS_SRE_RST;
            esr_q        <= 8'h00;
            opc_flag_q   <= 1'b0;
            cmd_ready_q  <= 1'b1;
            resp_valid_q <= 1'b0;
            resp_data_q  <= 16'h0000;
            setup_q      <= CCS_SETUP_RST;
            setup_load_q <= 1'b0;
            trigger_q    <= 1'b0;
            srq_q        <= 1'b0;
            stb_q        <= 8'h00;
        end else begin
            setup_load_q <= 1'b0;
            trigger_q    <= 1'b0;
            srq_q        <= srq_d;
            stb_q        <= stb_d;
            if (resp_taken_in) begin
                resp_valid_q <= 1'b0;
            end
            if (bad_loc) begin
                esr_q[CCS_ESR_CME_BIT] <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        case (cmd_code_in)
                            CCS_CMD_CLS: begin
                                esr_q      <= 8'h00;
                                opc_flag_q <= 1'b0;
                            end
                            CCS_CMD_ESE: ese_q <= cmd_arg_in;
                            CCS_CMD_ESE_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= {8'h00, ese_q};
                            end
                            CCS_CMD_ESR_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= {8'h00, esr_q};
                                esr_q        <= 8'h00;
                            end
                            CCS_CMD_IDN_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= {8'h00, CCS_ID_CODE};
                            end
                            CCS_CMD_LRN_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= setup_q;
                            end
                            CCS_CMD_OPC: begin
                                state_q     <= ST_WAIT_OPC;
                                cmd_ready_q <= 1'b0;
                            end
                            CCS_CMD_OPC_Q: begin
                                state_q     <= ST_WAIT_OPCQ;
                                cmd_ready_q <= 1'b0;
                            end
                            CCS_CMD_RCL: begin
                                if (loc_ok) begin
                                    setup_q      <= sif.rdata;
                                    setup_load_q <= 1'b1;
                                end
                            end
                            CCS_CMD_SAV: ;
                            CCS_CMD_RST: begin
                                ese_q        <= CCS_ESE_RST;
                                sre_q        <= CCS_SRE_RST;
                                opc_flag_q   <= 1'b0;
                                setup_q      <= CCS_SETUP_RST;
                                setup_load_q <= 1'b1;
                            end
                            CCS_CMD_SRE: sre_q <= cmd_arg_in;
                            CCS_CMD_SRE_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= {8'h00, sre_q};
                            end
                            CCS_CMD_STB_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= {8'h00, stb_q};
                            end
                            CCS_CMD_TRG: trigger_q <= 1'b1;
                            CCS_CMD_TST_Q: begin
                                resp_valid_q <= 1'b1;
                                resp_data_q  <= selftest_fail_in ? 16'h0001 : 16'h0000;
                            end
                            CCS_CMD_WAI: begin
                                state_q     <= ST_WAIT_WAI;
                                cmd_ready_q <= 1'b0;
                            end
                            default: esr_q[CCS_ESR_CME_BIT] <= 1'b1;
                        endcase
                    end
                end
                ST_WAIT_OPC: begin
                    if (idle_ops) begin
                        opc_flag_q             <= 1'b1;
                        esr_q[CCS_ESR_OPC_BIT] <= 1'b1;
                        state_q                <= ST_IDLE;
                        cmd_ready_q            <= 1'b1;
                    end
                end
                ST_WAIT_OPCQ: begin
                    if (idle_ops) begin
                        resp_valid_q <= 1'b1;
                        resp_data_q  <= {8'h00, CCS_ONE_ASCII};
                        state_q      <= ST_IDLE;
                        cmd_ready_q  <= 1'b1;
                    end
                end
                ST_WAIT_WAI: begin
                    if (idle_ops) begin
                        state_q     <= ST_IDLE;
                        cmd_ready_q <= 1'b1;
                    end
                end
                default: begin
                    state_q     <= ST_IDLE;
                    cmd_ready_q <= 1'b1;
                end
            endcase
        end
    end

    assign cmd_ready_out  = cmd_ready_q;
    assign resp_valid_out = resp_valid_q;
    assign resp_data_out  = resp_data_q;
    assign setup_out      = setup_q;
    assign setup_load_out = setup_load_q;
    assign trigger_out    = trigger_q;
    assign srq_out        = srq_q;
    assign stb_out        = stb_q;
    assign opc_flag_out   = opc_flag_q;

    AST_ESE_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_ESE |=> ese_q == $past(cmd_arg_in))
        else $error("ESE not loaded");
    AST_ESR_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_ESR_Q |=> resp_data_q[7:0] == $past(esr_q)
        && esr_q[CCS_ESR_OPC_BIT] == 1'b0)
        else $error("ESR query wrong");
    AST_CLS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_CLS |=> esr_q == 8'h00 && !opc_flag_q)
        else $error("Clear status failed");
    AST_OPC_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        opc_done |=> opc_flag_q && esr_q[CCS_ESR_OPC_BIT])
        else $error("OPC not set");
    AST_OPCQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == ST_WAIT_OPCQ && op_pending_in |=> !(resp_valid_q && $rose(resp_valid_q)))
        else $error("OPC query answered early");
    AST_WAI: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == ST_WAIT_WAI && op_pending_in |-> !cmd_ready_q)
        else $error("Wait did not stall");
    AST_SRE_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_SRE |=> sre_q == $past(cmd_arg_in))
        else $error("SRE not loaded");
    AST_SRQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        |(stb_d & sre_q & 8'hBF) |=> srq_q)
        else $error("Service request missing");
    AST_TRG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_TRG |=> trigger_q)
        else $error("Trigger pulse wrong");
    AST_TST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_TST_Q |=> resp_data_q == {15'h0000, $past(selftest_fail_in)})
        else $error("Self test answer wrong");

    AST_ESE_Q: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_ESE_Q |=> resp_valid_q
        && resp_data_q == {8'h00, $past(ese_q)} && ese_q == $past(ese_q))
        else $error("ESE query wrong");

    AST_SRE_Q: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_SRE_Q |=> resp_valid_q
        && resp_data_q == {8'h00, $past(sre_q)})
        else $error("SRE query wrong");

    AST_STB_Q: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_STB_Q |=> resp_valid_q
        && resp_data_q == {8'h00, $past(stb_q)})
        else $error("Status byte query wrong");

    AST_IDN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_IDN_Q |=> resp_valid_q
        && resp_data_q == {8'h00, CCS_ID_CODE})
        else $error("Identification answer wrong");

    AST_LRN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_LRN_Q |=> resp_valid_q
        && resp_data_q == $past(setup_q))
        else $error("Learn answer wrong");

    AST_RCL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_rcl |=> setup_q == $past(sif.rdata) && setup_load_q)
        else $error("Recall did not restore");

    AST_SAV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        is_sav |=> u_mem.mem_q[$past(sif.addr)] == $past(setup_in))
        else $error("Save did not store");

    AST_BAD_LOC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        bad_loc |=> esr_q[CCS_ESR_CME_BIT] && !setup_load_q)
        else $error("Bad location not flagged");

    AST_RST_MASKS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_RST |=> ese_q == CCS_ESE_RST
        && sre_q == CCS_SRE_RST && !opc_flag_q)
        else $error("Reset command left masks");

    AST_RST_SETUP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_RST |=> setup_q == CCS_SETUP_RST && setup_load_q)
        else $error("Reset command left setup");

    AST_CLS_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_CLS |=> resp_data_q == $past(resp_data_q)
        && resp_valid_q == ($past(resp_valid_q) && !$past(resp_taken_in)))
        else $error("Clear status touched output");

    AST_OPCQ_ANS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == ST_WAIT_OPCQ && !op_pending_in |=> resp_valid_q && cmd_ready_q
        && resp_data_q == {8'h00, CCS_ONE_ASCII})
        else $error("OPC query answer wrong");

    AST_OPC_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == ST_WAIT_OPC && op_pending_in |=> state_q == ST_WAIT_OPC && !cmd_ready_q)
        else $error("OPC did not wait");

    AST_WAI_ENTER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_WAI |=> state_q == ST_WAIT_WAI && !cmd_ready_q)
        else $error("Wait not entered");

    AST_WAI_LEAVE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == ST_WAIT_WAI && !op_pending_in |=> state_q == ST_IDLE && cmd_ready_q)
        else $error("Wait not released");

    AST_READY_STATE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_ready_q == (state_q == ST_IDLE))
        else $error("Ready out of step with state");

    AST_ESB: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> stb_q[CCS_STB_ESB_BIT] == $past(|(esr_q & ese_q)))
        else $error("Event summary bit wrong");

    AST_MAV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> stb_q[CCS_STB_MAV_BIT] == $past(resp_valid_q))
        else $error("Message bit wrong");

    AST_RQS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> stb_q[CCS_STB_RQS_BIT] == $past(srq_q))
        else $error("Request bit wrong");

    AST_SRQ_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(|(stb_d & sre_q & 8'hBF)) |=> !srq_q)
        else $error("Service request without cause");

    AST_TRG_ONLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trigger_q |-> $past(take && cmd_code_in == CCS_CMD_TRG))
        else $error("Trigger without command");

    AST_LOAD_ONLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        setup_load_q |-> $past(is_rcl || (take && cmd_code_in == CCS_CMD_RST)))
        else $error("Setup load without command");

    AST_RESP_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        resp_valid_q && !resp_taken_in |=> resp_valid_q)
        else $error("Response dropped early");

    AST_RESP_DROP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        resp_taken_in && !take && state_q != ST_WAIT_OPCQ |=> !resp_valid_q)
        else $error("Response not released");

    AST_TST_PASS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && cmd_code_in == CCS_CMD_TST_Q && !selftest_fail_in |=> resp_valid_q
        && resp_data_q == 16'h0000)
        else $error("Self test pass answer wrong");

    AST_ESE_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(take && (cmd_code_in == CCS_CMD_ESE || cmd_code_in == CCS_CMD_RST))
        |=> ese_q == $past(ese_q))
        else $error("ESE changed without command");
endmodule

// File: rtl/ccs_pkg.sv
// Package of constants and types for the common command and status unit.
package ccs_pkg;
    localparam int CCS_DATA_W = 8;
    localparam int CCS_SETUP_W = 16;
    localparam int CCS_LOCS = 4;
    localparam logic [4:0] CCS_CMD_CLS = 5'h00;
    localparam logic [4:0] CCS_CMD_ESE = 5'h01;
    localparam logic [4:0] CCS_CMD_ESE_Q = 5'h02;
    localparam logic [4:0] CCS_CMD_ESR_Q = 5'h03;
    localparam logic [4:0] CCS_CMD_IDN_Q = 5'h04;
    localparam logic [4:0] CCS_CMD_LRN_Q = 5'h05;
    localparam logic [4:0] CCS_CMD_OPC = 5'h06;
    localparam logic [4:0] CCS_CMD_OPC_Q = 5'h07;
    localparam logic [4:0] CCS_CMD_RCL = 5'h08;
    localparam logic [4:0] CCS_CMD_RST = 5'h09;
    localparam logic [4:0] CCS_CMD_SAV = 5'h0A;
    localparam logic [4:0] CCS_CMD_SRE = 5'h0B;
    localparam logic [4:0] CCS_CMD_SRE_Q = 5'h0C;
    localparam logic [4:0] CCS_CMD_STB_Q = 5'h0D;
    localparam logic [4:0] CCS_CMD_TRG = 5'h0E;
    localparam logic [4:0] CCS_CMD_TST_Q = 5'h0F;
    localparam logic [4:0] CCS_CMD_WAI = 5'h10;
    localparam int CCS_ESR_OPC_BIT = 0;
    localparam int CCS_ESR_CME_BIT = 5;
    localparam int CCS_STB_ESB_BIT = 5;
    localparam int CCS_STB_MAV_BIT = 4;
    localparam int CCS_STB_RQS_BIT = 6;
    localparam logic [7:0] CCS_ESE_RST = 8'h00;
    localparam logic [7:0] CCS_SRE_RST = 8'h00;
    localparam logic [15:0] CCS_SETUP_RST = 16'h0000;
    localparam logic [7:0] CCS_ONE_ASCII = 8'h31;
    localparam logic [7:0] CCS_ZERO_ASCII = 8'h30;
    localparam logic [7:0] CCS_ID_CODE = 8'h5A;
    typedef logic [4:0] ccs_cmd_type;
endpackage

// File: rtl/ccs_setup_if.sv
// Interface carrying setup store traffic between the unit and its memory.
`timescale 1ns/1ps
interface ccs_setup_if;
    logic       wr;
    logic [1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl (output wr, output addr, output wdata, input rdata);
    modport mem (input wr, input addr, input wdata, output rdata);
endinterface

// File: rtl/ccs_setup_mem.sv
// Four-location memory for saved instrument setups.
`timescale 1ns/1ps
module ccs_setup_mem #(
    parameter int DEPTH = 4
) (
    input  wire logic  clk_in,
    ccs_setup_if.mem   port
);
    import ccs_pkg::*;
    logic [15:0] mem_q [DEPTH];
    always_ff @(posedge clk_in) begin
        if (port.wr) begin
            mem_q[port.addr] <= port.wdata;
        end
    end
    assign port.rdata = mem_q[port.addr];
endmodule

// File: tb/ccs_host_model.sv
// Host controller model that issues commands and collects responses.
`timescale 1ns/1ps
module ccs_host_model (
    input  wire logic            clk_in,
    input  wire logic            cmd_ready_in,
    input  wire logic            resp_valid_in,
    input  wire logic [15:0]     resp_data_in,
    output logic                 cmd_valid_out,
    output ccs_pkg::ccs_cmd_type cmd_code_out,
    output logic [7:0]           cmd_arg_out,
    output logic                 resp_taken_out,
    output logic                 timeout_out
);
    import ccs_pkg::*;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 5'h00;
        cmd_arg_out = 8'h00;
        resp_taken_out = 1'b0;
        timeout_out = 1'b0;
    end
    // Holds a command until an edge sees ready, then drives the inverse.
    task automatic send(input ccs_cmd_type code, input logic [7:0] arg);
        int n;
        n = 0;
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_arg_out = arg;
        while (cmd_ready_in !== 1'b1 && n < 500) begin
            @(negedge clk_in);
            n++;
        end
        timeout_out = timeout_out | (n >= 500);
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_code_out = ~code;
        cmd_arg_out = ~arg;
    endtask
    // Waits for a response, takes its data and pulses the consume strobe.
    task automatic take(output logic [15:0] data);
        int n;
        n = 0;
        while (resp_valid_in !== 1'b1 && n < 500) begin
            @(negedge clk_in);
            n++;
        end
        timeout_out = timeout_out | (n >= 500);
        data = resp_data_in;
        resp_taken_out = 1'b1;
        @(negedge clk_in);
        resp_taken_out = 1'b0;
    endtask
endmodule

// File: tb/ccs_unit_tb.sv
// Self-checking testbench for the common command and status unit.
`timescale 1ns/1ps
module ccs_unit_tb;
    import ccs_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        pend = 1'b0;
    logic        tfail = 1'b0;
    logic [15:0] sin = 16'h0000;
    logic        vld, rdy, rv, rt, ld, trg, srq, opc, tmo;
    ccs_cmd_type code;
    logic [7:0]  arg, stb;
    logic [15:0] rdat, sout, rd;
    int          err_total = 0;
    int          n_checks = 0;
    int          trig_cnt = 0;
    int          load_cnt = 0;
    int          t0;
    always #25 clk_in = ~clk_in;
    ccs_unit DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(vld),
        .cmd_code_in(code), .cmd_arg_in(arg), .op_pending_in(pend),
        .selftest_fail_in(tfail), .setup_in(sin), .resp_taken_in(rt),
        .cmd_ready_out(rdy), .resp_valid_out(rv), .resp_data_out(rdat),
        .setup_out(sout), .setup_load_out(ld), .trigger_out(trg),
        .srq_out(srq), .stb_out(stb), .opc_flag_out(opc));
    ccs_host_model HOST (.clk_in(clk_in), .cmd_ready_in(rdy), .resp_valid_in(rv),
        .resp_data_in(rdat), .cmd_valid_out(vld), .cmd_code_out(code),
        .cmd_arg_out(arg), .resp_taken_out(rt), .timeout_out(tmo));
    always @(negedge clk_in) begin
        if (trg === 1'b1) trig_cnt++;
        if (ld === 1'b1) load_cnt++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic query(input ccs_cmd_type c, input logic [7:0] a);
        HOST.send(c, a);
        HOST.take(rd);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        chk("ready", 16'h0001, 16'(rdy));
        chk("stb", 16'h0000, {8'h00, stb});
        chk("srq", 16'h0000, 16'(srq));
        $display("Test reset done");
        HOST.send(CCS_CMD_ESE, 8'hA5);
        query(CCS_CMD_ESE_Q, 8'h00);
        chk("ese", 16'h00A5, rd);
        query(CCS_CMD_ESE_Q, 8'h00);
        chk("ese again", 16'h00A5, rd);
        HOST.send(CCS_CMD_SRE, 8'h20);
        query(CCS_CMD_SRE_Q, 8'h00);
        chk("sre", 16'h0020, rd);
        query(CCS_CMD_IDN_Q, 8'h00);
        chk("idn", {8'h00, CCS_ID_CODE}, rd);
        query(CCS_CMD_TST_Q, 8'h00);
        chk("tst pass", 16'h0000, rd);
        tfail = 1'b1;
        query(CCS_CMD_TST_Q, 8'h00);
        chk("tst fail", 16'h0001, rd);
        tfail = 1'b0;
        $display("Test registers done");
        for (int i = 1; i <= 4; i++) begin
            sin = 16'hC000 + 16'(i);
            HOST.send(CCS_CMD_SAV, 8'(i));
        end
        for (int i = 4; i >= 1; i--) begin
            sin = 16'hC000 + 16'(i);
            HOST.send(CCS_CMD_RCL, 8'(i));
            repeat (2) @(negedge clk_in);
            chk("recall", 16'hC000 + 16'(i), sout);
            query(CCS_CMD_LRN_Q, 8'h00);
            chk("learn", 16'hC000 + 16'(i), rd);
        end
        chk("loads", 16'h0004, 16'(load_cnt));
        $display("Test setups done");
        HOST.send(CCS_CMD_SAV, 8'h00);
        HOST.send(CCS_CMD_RCL, 8'h05);
        repeat (2) @(negedge clk_in);
        chk("bad recall", 16'hC001, sout);
        chk("srq set", 16'h0001, 16'(srq));
        query(CCS_CMD_STB_Q, 8'h00);
        chk("stb query", 16'h0060, rd & 16'h0060);
        pend = 1'b1;
        HOST.send(CCS_CMD_OPC, 8'h00);
        repeat (5) @(negedge clk_in);
        chk("opc early", 16'h0000, 16'(opc));
        pend = 1'b0;
        repeat (3) @(negedge clk_in);
        chk("opc flag", 16'h0001, 16'(opc));
        query(CCS_CMD_ESR_Q, 8'h00);
        chk("esr", 16'h0021, rd);
        query(CCS_CMD_ESR_Q, 8'h00);
        chk("esr cleared", 16'h0000, rd);
        repeat (2) @(negedge clk_in);
        chk("srq clear", 16'h0000, 16'(srq));
        $display("Test status done");
        pend = 1'b1;
        HOST.send(CCS_CMD_OPC_Q, 8'h00);
        repeat (4) @(negedge clk_in);
        chk("opcq early", 16'h0000, 16'(rv));
        pend = 1'b0;
        HOST.take(rd);
        chk("opcq", {8'h00, CCS_ONE_ASCII}, rd);
        t0 = trig_cnt;
        HOST.send(CCS_CMD_TRG, 8'h00);
        repeat (2) @(negedge clk_in);
        chk("trigger", 16'h0001, 16'(trig_cnt - t0));
        pend = 1'b1;
        HOST.send(CCS_CMD_WAI, 8'h00);
        repeat (4) @(negedge clk_in);
        chk("wai stall", 16'h0000, 16'(rdy));
        pend = 1'b0;
        repeat (2) @(negedge clk_in);
        chk("wai release", 16'h0001, 16'(rdy));
        $display("Test opc trigger wait done");
        HOST.send(CCS_CMD_SAV, 8'h07);
        HOST.send(CCS_CMD_IDN_Q, 8'h00);
        HOST.send(CCS_CMD_CLS, 8'h00);
        repeat (2) @(negedge clk_in);
        chk("cls opc", 16'h0000, 16'(opc));
        chk("cls srq", 16'h0000, 16'(srq));
        chk("cls resp", 16'h0001, 16'(rv));
        HOST.take(rd);
        chk("cls out", {8'h00, CCS_ID_CODE}, rd);
        $display("Test clear done");
        HOST.send(CCS_CMD_RST, 8'h00);
        query(CCS_CMD_ESE_Q, 8'h00);
        chk("rst ese", {8'h00, CCS_ESE_RST}, rd);
        query(CCS_CMD_SRE_Q, 8'h00);
        chk("rst sre", {8'h00, CCS_SRE_RST}, rd);
        chk("rst setup", CCS_SETUP_RST, sout);
        chk("host waits", 16'h0000, 16'(tmo));
        $display("Test reset command done");
        end_of_test;
    end
endmodule
